// [core/csc_pkg.sv]
// package for the cas signalling bit conditioner
package csc_pkg;
   // per-bit mode codes
   typedef enum logic [1:0] {
      CSC_MODE_PASS = 2'b00,
      CSC_MODE_INV = 2'b01,
      CSC_MODE_ONE = 2'b10,
      CSC_MODE_ZERO = 2'b11
   } csc_mode_t;

   localparam int CSC_NUM_FIELDS = 6;
   localparam int CSC_ADDR_W = 4;

   // register offsets
   localparam logic [3:0] CSC_REG_PEND = 4'h0;
   localparam logic [3:0] CSC_REG_ACTIVE = 4'h1;
   localparam logic [3:0] CSC_REG_CMD = 4'h2;
   localparam logic [3:0] CSC_REG_STATUS = 4'h3;

   // mode field positions inside the setting word
   localparam int CSC_F_XS_A = 0;
   localparam int CSC_F_XS_B = 2;
   localparam int CSC_F_XS_C = 4;
   localparam int CSC_F_XS_D = 6;
   localparam int CSC_F_XO_A = 8;
   localparam int CSC_F_TR_A = 10;
   localparam int CSC_CFG_W = 12;

   // command bits
   localparam int CSC_CMD_APPLY = 0;
   localparam int CSC_CMD_DISCARD = 1;

   localparam logic [CSC_CFG_W-1:0] CSC_CFG_RST = 12'h000;
   localparam logic [31:0] CSC_RD_UNMAPPED = 32'h0000_0000;

   // idle levels of the cas lines, held in reset and while the sync pipe refills
   localparam logic [3:0] CSC_CAS4_IDLE = 4'hf;
   localparam logic [1:0] CSC_CAS2_IDLE = 2'h3;
   localparam logic CSC_CAS1_IDLE = 1'b1;
   // zero fill above the setting word and above the status bit on reads
   localparam logic [31-CSC_CFG_W:0] CSC_RD_CFG_PAD = 20'h00000;
   localparam logic [30:0] CSC_RD_STAT_PAD = 31'h00000000;
endpackage

// [core/csc_conditioner.sv]
// cas signalling bit conditioner with pending and active settings
`timescale 1ns/10ps
// Summary of operation
// RULE_01 - condition ABCD toward subscriber card, A toward exchange card.
// RULE_02 - one setting shared by both exchange-side ports.
// RULE_03 - transparent normal passes bit unchanged; reset default.
// RULE_04 - transparent inverted passes bit inverted.
// RULE_05 - forced normal drives bit to 1.
// RULE_06 - forced inverted drives bit to 0.
// RULE_07 - subscriber-bound A: 1 no fault, 0 fault.
// RULE_08 - subscriber-bound B: 1 no ringing, 0 ringing.
// RULE_09 - subscriber-bound C: 1 no billing tone, 0 billing tone.
// RULE_10 - subscriber-bound D: 1 no reversal, 0 reversal.
// RULE_11 - exchange-bound A: 1 not off-hook, 0 off-hook.
// RULE_12 - trunk to subscriber: only A conditioned, ringing; B C D unused.
// RULE_13 - subscriber to trunk A: 1 idle, 0 off-hook.
// RULE_14 - software uses forced modes to disable functions or test.
// RULE_15 - edits act only on apply; discard restores active settings.
// RULE_16 - two-bit mode per bit: 00 pass,01 invert,10 one,11 zero.
module csc_conditioner
   import csc_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [CSC_ADDR_W-1:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // exchange card to subscriber card, ports 0 and 1, bits {a,b,c,d} = [3:0]
   input wire logic [3:0] xo0_cas_i,
   input wire logic [3:0] xo1_cas_i,
   output logic [3:0] xs0_cas_o,
   output logic [3:0] xs1_cas_o,
   // subscriber card to exchange card, bit a
   input wire logic [1:0] xs_hook_i,
   output logic [1:0] xo_hook_o,
   // trunk card to subscriber card and back, bit a
   input wire logic trunk_ring_i,
   output logic trunk_ring_o,
   input wire logic sub_hook_i,
   output logic sub_hook_o
);

   // applies one mode code to one bit
   function automatic logic cond_bit(input logic [1:0] mode, input logic din);
      logic r;
      r = din;
      case (csc_mode_t'(mode))
         CSC_MODE_PASS: r = din; // [RULE_03]
         CSC_MODE_INV: r = ~din; // [RULE_04]
         CSC_MODE_ONE: r = 1'b1; // [RULE_05]
         CSC_MODE_ZERO: r = 1'b0; // [RULE_06]
         default: r = din;
      endcase
      return r;
   endfunction

   // picks one two-bit mode field out of a setting word
   function automatic logic [1:0] field_mode(input logic [CSC_CFG_W-1:0] cfg, input int pos);
      logic [1:0] m;
      m = cfg[pos+:2];
      return m;
   endfunction

   logic [CSC_CFG_W-1:0] pend_q, pend_d;
   logic [CSC_CFG_W-1:0] act_q, act_d;
   logic dirty_q, dirty_d;
   logic [31:0] rdata_q, rdata_d;

   // pins are from other cards: two flops before use
   // pin to pin is three edges; cas bits move at frame rate, so the delay is harmless
   logic [3:0] xo0_s1_q, xo0_s2_q, xo1_s1_q, xo1_s2_q;
   logic [3:0] xo0_s1_d, xo0_s2_d, xo1_s1_d, xo1_s2_d;
   logic [1:0] hk_s1_q, hk_s2_q, hk_s1_d, hk_s2_d;
   logic tr_s1_q, tr_s2_q, sh_s1_q, sh_s2_q;
   logic tr_s1_d, tr_s2_d, sh_s1_d, sh_s2_d;

   // exchange card cas bits on their way to the subscriber card
   always_comb begin
      xo0_s1_d = xo0_cas_i;
      xo0_s2_d = xo0_s1_q;
      xo1_s1_d = xo1_cas_i;
      xo1_s2_d = xo1_s1_q;
   end

   // preset to idle so the first edges after reset show no false fault or ring
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         xo0_s1_q <= CSC_CAS4_IDLE;
         xo0_s2_q <= CSC_CAS4_IDLE;
         xo1_s1_q <= CSC_CAS4_IDLE;
         xo1_s2_q <= CSC_CAS4_IDLE;
      end else begin
         xo0_s1_q <= xo0_s1_d;
         xo0_s2_q <= xo0_s2_d;
         xo1_s1_q <= xo1_s1_d;
         xo1_s2_q <= xo1_s2_d;
      end
   end

   // hook bits from the subscriber card, one per exchange port
   always_comb begin
      hk_s1_d = xs_hook_i;
      hk_s2_d = hk_s1_q;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hk_s1_q <= CSC_CAS2_IDLE;
         hk_s2_q <= CSC_CAS2_IDLE;
      end else begin
         hk_s1_q <= hk_s1_d;
         hk_s2_q <= hk_s2_d;
      end
   end

   // trunk ring bit toward the subscriber card
   always_comb begin
      tr_s1_d = trunk_ring_i;
      tr_s2_d = tr_s1_q;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tr_s1_q <= CSC_CAS1_IDLE;
         tr_s2_q <= CSC_CAS1_IDLE;
      end else begin
         tr_s1_q <= tr_s1_d;
         tr_s2_q <= tr_s2_d;
      end
   end

   // hook bit from the subscriber card back toward the trunk
   always_comb begin
      sh_s1_d = sub_hook_i;
      sh_s2_d = sh_s1_q;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sh_s1_q <= CSC_CAS1_IDLE;
         sh_s2_q <= CSC_CAS1_IDLE;
      end else begin
         sh_s1_q <= sh_s1_d;
         sh_s2_q <= sh_s2_d;
      end
   end

   // write decode; apply wins over discard when one write sets both bits
   logic wr_pend, do_apply, do_discard;

   always_comb begin
      wr_pend = 1'b0;
      do_apply = 1'b0;
      do_discard = 1'b0;
      if (reg_wr_i) begin
         if (reg_addr_i == CSC_REG_PEND) begin
            wr_pend = 1'b1;
         end else if (reg_addr_i == CSC_REG_CMD) begin
            do_apply = reg_wdata_i[CSC_CMD_APPLY];
            do_discard = !reg_wdata_i[CSC_CMD_APPLY] && reg_wdata_i[CSC_CMD_DISCARD];
         end
      end
   end

   // settings: edits land in pending, apply copies to active
   always_comb begin
      pend_d = pend_q;
      act_d = act_q;
      dirty_d = dirty_q;
      if (wr_pend) begin
         pend_d = reg_wdata_i[CSC_CFG_W-1:0];
         dirty_d = 1'b1;
      end
      if (do_apply) begin
         act_d = pend_q; // [RULE_15]
         dirty_d = 1'b0;
      end
      if (do_discard) begin
         pend_d = act_q; // [RULE_15]
         dirty_d = 1'b0;
      end
   end

   // register read, data in the following cycle
   // the command index has nothing to read back and reads as unmapped
   always_comb begin
      rdata_d = CSC_RD_UNMAPPED;
      if (reg_rd_i) begin
         if (reg_addr_i == CSC_REG_PEND) begin
            rdata_d = {CSC_RD_CFG_PAD, pend_q};
         end else if (reg_addr_i == CSC_REG_ACTIVE) begin
            rdata_d = {CSC_RD_CFG_PAD, act_q};
         end else if (reg_addr_i == CSC_REG_STATUS) begin
            rdata_d = {CSC_RD_STAT_PAD, dirty_q};
         end
      end
   end

   // pending and active both start as pass-through on every bit
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_q <= CSC_CFG_RST; // [RULE_16]
         act_q <= CSC_CFG_RST; // [RULE_03]
         dirty_q <= 1'b0;
         rdata_q <= CSC_RD_UNMAPPED;
      end else begin
         pend_q <= pend_d;
         act_q <= act_d;
         dirty_q <= dirty_d;
         rdata_q <= rdata_d;
      end
   end

   // conditioned outputs; bit order [3]=a,[2]=b,[1]=c,[0]=d
   logic [3:0] xs0_d, xs1_d;
   logic [1:0] hk_d;
   logic tr_d, sh_d;
   logic [1:0] mode_fault, mode_ring, mode_bill, mode_rev;
   logic [1:0] mode_hook, mode_trunk;

   // modes come from the active word only, so an edit in progress never reaches a line
   // field positions live in the package so the layout has one home
   always_comb begin
      mode_fault = field_mode(act_q, CSC_F_XS_A);
      mode_ring = field_mode(act_q, CSC_F_XS_B);
      mode_bill = field_mode(act_q, CSC_F_XS_C);
      mode_rev = field_mode(act_q, CSC_F_XS_D);
      mode_hook = field_mode(act_q, CSC_F_XO_A);
      mode_trunk = field_mode(act_q, CSC_F_TR_A);
   end

   // same active word feeds both exchange ports [RULE_02]
   always_comb begin
      xs0_d[3] = cond_bit(mode_fault, xo0_s2_q[3]); // fault [RULE_07] [RULE_01]
      xs0_d[2] = cond_bit(mode_ring, xo0_s2_q[2]); // ringing [RULE_08]
      xs0_d[1] = cond_bit(mode_bill, xo0_s2_q[1]); // billing tone [RULE_09]
      xs0_d[0] = cond_bit(mode_rev, xo0_s2_q[0]); // reversal [RULE_10]
      xs1_d[3] = cond_bit(mode_fault, xo1_s2_q[3]); // [RULE_07]
      xs1_d[2] = cond_bit(mode_ring, xo1_s2_q[2]); // [RULE_08]
      xs1_d[1] = cond_bit(mode_bill, xo1_s2_q[1]); // [RULE_09]
      xs1_d[0] = cond_bit(mode_rev, xo1_s2_q[0]); // [RULE_10]
   end

   // subscriber to exchange: hook state, one bit per port
   always_comb begin
      hk_d[0] = cond_bit(mode_hook, hk_s2_q[0]); // hook state [RULE_11] [RULE_01]
      hk_d[1] = cond_bit(mode_hook, hk_s2_q[1]); // [RULE_11]
   end

   // trunk path carries only bit a; b c d do not exist here
   always_comb begin
      tr_d = cond_bit(mode_trunk, tr_s2_q); // [RULE_12]
      sh_d = cond_bit(mode_trunk, sh_s2_q); // idle 1, off-hook 0 [RULE_13]
   end

   // idle toward the subscriber card: no fault, ring, tone or reversal
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         xs0_cas_o <= CSC_CAS4_IDLE;
      end else begin
         xs0_cas_o <= xs0_d;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         xs1_cas_o <= CSC_CAS4_IDLE;
      end else begin
         xs1_cas_o <= xs1_d;
      end
   end

   // idle toward the exchange card is on-hook
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         xo_hook_o <= CSC_CAS2_IDLE;
      end else begin
         xo_hook_o <= hk_d;
      end
   end

   // trunk ring bit rests at no ringing
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         trunk_ring_o <= CSC_CAS1_IDLE;
      end else begin
         trunk_ring_o <= tr_d;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sub_hook_o <= CSC_CAS1_IDLE;
      end else begin
         sub_hook_o <= sh_d;
      end
   end

   assign reg_rdata_o = rdata_q;

endmodule

// [testbench/csc_peer_model.sv]
// peer card model driving the cas levels
`timescale 1ns/10ps
module csc_peer_model (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic step_i,
   output logic [11:0] line_o
);
   // twisted ring: every line both rises and falls over the steps
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) line_o <= 12'h5a3;
      else if (step_i) line_o <= {line_o[10:0], ~line_o[11]};
   end
endmodule

// [testbench/csc_conditioner_properties.sv]
// port checker for the cas conditioner
`timescale 1ns/10ps
module csc_chk import csc_pkg::*; (
   input wire logic core_clk_i, rst_n_i, reg_wr_i, reg_rd_i,
   input wire logic trunk_ring_i, trunk_ring_o, sub_hook_i, sub_hook_o,
   input wire logic [CSC_ADDR_W-1:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i, reg_rdata_o,
   input wire logic [3:0] xo0_cas_i, xo1_cas_i, xs0_cas_o, xs1_cas_o,
   input wire logic [1:0] xs_hook_i, xo_hook_o
);
   logic [11:0] p_q, a_q;
   logic [1:0] n_q;
   logic d_q;
   wire cmd = reg_wr_i && reg_addr_i == CSC_REG_CMD;
   wire ok = n_q == 2'h3;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   function automatic logic f(logic [1:0] m, logic b);
      return m[1] ? ~m[0] : b ^ m[0];
   endfunction
   function automatic logic [3:0] g(logic [7:0] m, logic [3:0] b);
      return {f(m[1:0], b[3]), f(m[3:2], b[2]), f(m[5:4], b[1]), f(m[7:6], b[0])};
   endfunction
   // n_q waits out the pipe refill after reset or a command
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) {p_q, a_q, n_q, d_q} <= 27'h0;
      else begin
         n_q <= cmd ? 2'h0 : n_q + 2'(n_q != 2'h3);
         if (reg_wr_i && reg_addr_i == CSC_REG_PEND) d_q <= 1'b1;
         else if (cmd && (reg_wdata_i[0] || reg_wdata_i[1])) d_q <= 1'b0;
         if (reg_wr_i && reg_addr_i == CSC_REG_PEND) p_q <= reg_wdata_i[11:0];
         if (cmd && reg_wdata_i[0]) a_q <= p_q;
         else if (cmd && reg_wdata_i[1]) p_q <= a_q;
      end
   end
   a_sub_bits: assert property (ok |-> xs0_cas_o == g(a_q[7:0], $past(xo0_cas_i, 3))) else $error("sub");
   a_port_pair: assert property (ok |-> xs1_cas_o == g(a_q[7:0], $past(xo1_cas_i, 3))) else $error("port");
   a_hook_back: assert property (ok |-> xo_hook_o ==
      {f(a_q[9:8], $past(xs_hook_i[1], 3)), f(a_q[9:8], $past(xs_hook_i[0], 3))}) else $error("hook");
   a_trunk_pair: assert property (ok |-> {trunk_ring_o, sub_hook_o} ==
      {f(a_q[11:10], $past(trunk_ring_i, 3)), f(a_q[11:10], $past(sub_hook_i, 3))}) else $error("trunk");
   a_read_active: assert property ($past(reg_rd_i) && $past(reg_addr_i) == CSC_REG_ACTIVE
      |-> reg_rdata_o[11:0] == a_q) else $error("active");
   a_read_pend: assert property ($past(reg_rd_i) && $past(reg_addr_i) == CSC_REG_PEND
      |-> reg_rdata_o[11:0] == p_q) else $error("pend");
   a_read_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0) else $error("idle");
   a_status_dirty: assert property ($past(reg_rd_i) && $past(reg_addr_i) == CSC_REG_STATUS
      |-> reg_rdata_o == {31'h0, d_q}) else $error("status");
   a_read_unmap: assert property ($past(reg_rd_i) && $past(reg_addr_i) > 4'h3
      |-> reg_rdata_o == CSC_RD_UNMAPPED) else $error("unmap");
   c_apply: cover property (cmd && reg_wdata_i[0]);
   c_discard: cover property (cmd && reg_wdata_i[1]);
   c_unmap: cover property (reg_rd_i && reg_addr_i > 4'h3);
endmodule
bind csc_conditioner csc_chk csc_chk_inst (
   .core_clk_i(core_clk_i),
   .rst_n_i(rst_n_i),
   .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i),
   .trunk_ring_i(trunk_ring_i),
   .trunk_ring_o(trunk_ring_o),
   .sub_hook_i(sub_hook_i),
   .sub_hook_o(sub_hook_o),
   .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o),
   .xo0_cas_i(xo0_cas_i),
   .xo1_cas_i(xo1_cas_i),
   .xs0_cas_o(xs0_cas_o),
   .xs1_cas_o(xs1_cas_o),
   .xs_hook_i(xs_hook_i),
   .xo_hook_o(xo_hook_o)
);

// [testbench/tb_top.sv]
// bench for the cas conditioner
`timescale 1ns/10ps
module tb_top import csc_pkg::*; ;
   logic core_clk_i = 1'h0, rst_n_i, reg_wr_i = 1'h0, reg_rd_i = 1'h0, step_i = 1'h0;
   logic [3:0] reg_addr_i = 4'h0, xo0_cas_i, xo1_cas_i, xs0_cas_o, xs1_cas_o;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
   logic [1:0] xs_hook_i, xo_hook_o;
   logic trunk_ring_i, trunk_ring_o, sub_hook_i, sub_hook_o;
   logic [11:0] line;
   int mismatches = 0, checks = 0;
   assign {xo0_cas_i, xo1_cas_i, xs_hook_i, trunk_ring_i, sub_hook_i} = line;
   initial forever #4 core_clk_i = ~core_clk_i;
   csc_peer_model csc_peer_model_inst (.core_clk_i, .rst_n_i, .step_i, .line_o(line));
   csc_conditioner csc_conditioner_inst (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o),
      .xo0_cas_i(xo0_cas_i),
      .xo1_cas_i(xo1_cas_i),
      .xs0_cas_o(xs0_cas_o),
      .xs1_cas_o(xs1_cas_o),
      .xs_hook_i(xs_hook_i),
      .xo_hook_o(xo_hook_o),
      .trunk_ring_i(trunk_ring_i),
      .trunk_ring_o(trunk_ring_o),
      .sub_hook_i(sub_hook_i),
      .sub_hook_o(sub_hook_o)
   );
   task automatic cmp(string n, logic [31:0] e, s);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s exp %h seen %h", n, e, s);
      end
   endtask
   // one register access; a read expects d in the cycle after the strobe
   task automatic acc(logic w, logic [3:0] a, logic [31:0] d);
      @(posedge core_clk_i);
      {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {w, !w, a, d};
      @(posedge core_clk_i);
      {reg_wr_i, reg_rd_i} <= 2'h0;
      @(negedge core_clk_i);
      if (!w) cmp("rdata", d, reg_rdata_o);
   endtask
   function automatic logic [3:0] x(logic [1:0] m, logic [3:0] b);
      return m == 2'h0 ? b : m == 2'h1 ? ~b : {4{m == 2'h2}};
   endfunction
   task automatic cas(logic [1:0] m);
      @(posedge core_clk_i);
      step_i <= 1'h1;
      @(posedge core_clk_i);
      step_i <= 1'h0;
      repeat (4) @(posedge core_clk_i);
      @(negedge core_clk_i);
      cmp("sub0", x(m, xo0_cas_i), xs0_cas_o);
      cmp("sub1", x(m, xo1_cas_i), xs1_cas_o);
      cmp("hook", x(m, {xs_hook_i, 2'h0}) >> 2, xo_hook_o);
      cmp("trunk", x(m, {trunk_ring_i, sub_hook_i, 2'h0}) >> 2, {trunk_ring_o, sub_hook_o});
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      rst_n_i = 1'h0;
      repeat (12) @(posedge core_clk_i);
      rst_n_i <= 1'h1;
      acc(1'h0, CSC_REG_ACTIVE, 32'h0);
      for (int m = 0; m < 4; m++) begin
         acc(1'h1, CSC_REG_PEND, {20'h0, {6{2'(m)}}});
         acc(1'h0, CSC_REG_STATUS, 32'h1);
         cas(2'(m == 0 ? 0 : m - 1));
         acc(1'h1, CSC_REG_CMD, 32'h1);
         acc(1'h0, CSC_REG_STATUS, 32'h0);
         cas(2'(m));
         $display("test mode %0d done", m);
      end
      acc(1'h1, CSC_REG_PEND, 32'h555);
      acc(1'h0, CSC_REG_STATUS, 32'h1);
      acc(1'h1, CSC_REG_CMD, 32'h2);
      acc(1'h0, CSC_REG_STATUS, 32'h0);
      acc(1'h0, CSC_REG_PEND, 32'hfff);
      acc(1'h1, CSC_REG_ACTIVE, 32'h0);
      acc(1'h0, CSC_REG_ACTIVE, 32'hfff);
      acc(1'h0, 4'hf, CSC_RD_UNMAPPED);
      cas(2'h3);
      $display("test discard done");
      @(posedge core_clk_i);
      rst_n_i <= 1'h0;
      repeat (2) @(posedge core_clk_i);
      rst_n_i <= 1'h1;
      acc(1'h0, CSC_REG_ACTIVE, 32'h0);
      acc(1'h0, CSC_REG_PEND, 32'h0);
      acc(1'h0, CSC_REG_STATUS, 32'h0);
      cas(2'h0);
      $display("test reset done");
      give_verdict;
   end
   initial begin
      #20us;
      mismatches++;
      give_verdict;
   end
endmodule
